// *** logic/dtr_trigger_status.sv ***
`timescale 1ns/1ps
module dtr_trigger_status (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    // Register port
    input  wire logic [1:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        reg_write_i,
    input  wire logic        reg_read_i,
    output logic      [7:0]  reg_rdata_o,
    // Security strap from outside domain
    input  wire logic        secure_i,
    // Bus observation
    input  wire logic        bus_access_i,
    input  wire logic        opcode_exec_i,
    input  wire logic        match_a_addr_i,
    input  wire logic        match_b_addr_i,
    input  wire logic        match_b_data_i,
    input  wire logic        addr_ge_a_i,
    input  wire logic        addr_le_b_i,
    // Capture outputs
    output logic             fifo_store_o,
    output logic             high_byte_zero_o,
    output logic             break_req_o,
    output logic             trigger_o
);

    dtr_pkg::dtr_state_t state_reg;
    dtr_pkg::dtr_state_t state_next;

    logic [7:0] cfg_reg;
    logic [7:0] ctl_reg;
    logic       af_reg;
    logic       bf_reg;
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    logic       a_seen_reg;
    logic       sec_meta_reg;
    logic       sec_reg;
    logic [7:0] rdata_reg;
    logic       store_reg;
    logic       brk_reg;
    logic       trg_reg;
    logic       hbz_reg;

    // Mode decode used in several places
    function automatic logic is_event_mode(input logic [3:0] mode);
        is_event_mode = (mode == dtr_pkg::MODE_EVENT_B) ||
                        (mode == dtr_pkg::MODE_A_EVENT_B);
    endfunction

    // Register port decode
    wire wr_cfg  = reg_write_i && (reg_addr_i == dtr_pkg::ADDR_TRIG_CFG);
    wire wr_ctl  = reg_write_i && (reg_addr_i == dtr_pkg::ADDR_CONTROL);
    wire [3:0] mode = cfg_reg[3:0];
    wire event_mode = is_event_mode(mode);
    wire enabled    = ctl_reg[dtr_pkg::CTL_ENABLE_BIT];
    wire armed      = ctl_reg[dtr_pkg::CTL_RUN_BIT];

    // Run start and manual stop
    wire start_run = wr_ctl && reg_wdata_i[dtr_pkg::CTL_RUN_BIT] &&
                     reg_wdata_i[dtr_pkg::CTL_ENABLE_BIT] && !armed &&
                     !(sec_reg && !enabled);
    wire manual_stop = wr_ctl && armed &&
                       (!reg_wdata_i[dtr_pkg::CTL_RUN_BIT] ||
                        !reg_wdata_i[dtr_pkg::CTL_ENABLE_BIT]);

    // Execution qualification of raw matches
    wire qual = cfg_reg[dtr_pkg::CFG_QUALIFY_BIT] ?
                opcode_exec_i : bus_access_i;
    wire hit_a = qual && match_a_addr_i;
    wire hit_b = qual && match_b_addr_i;
    wire in_range = qual && addr_ge_a_i && addr_le_b_i;

    // Trigger condition per mode
    logic trig_now;
    always_comb
    begin
        case (mode)
            dtr_pkg::MODE_A_ONLY:    trig_now = hit_a;
            dtr_pkg::MODE_A_OR_B:    trig_now = hit_a || hit_b;
            dtr_pkg::MODE_A_THEN_B:  trig_now = hit_b && a_seen_reg;
            dtr_pkg::MODE_EVENT_B:   trig_now = hit_b;
            dtr_pkg::MODE_A_EVENT_B: trig_now = hit_b && a_seen_reg;
            dtr_pkg::MODE_A_AND_B:   trig_now = hit_a &&
                                                match_b_data_i;
            dtr_pkg::MODE_A_AND_NB:  trig_now = hit_a &&
                                                !match_b_data_i;
            dtr_pkg::MODE_INSIDE:    trig_now = in_range;
            dtr_pkg::MODE_OUTSIDE:   trig_now = qual &&
                                      !(addr_ge_a_i && addr_le_b_i);
            default:                 trig_now = 1'b0;
        endcase
    end

    // Begin trace is forced in event-only modes
    wire begin_trace = event_mode ||
                       cfg_reg[dtr_pkg::CFG_BEGIN_BIT];
    wire running    = armed && enabled;
    wire storing    = running && (state_reg == dtr_pkg::ST_STORE);
    wire store_word = event_mode ? (storing && hit_b) : storing;
    wire cnt_full   = (cnt_reg == dtr_pkg::FIFO_FULL_COUNT);
    wire fill_done  = begin_trace && store_word &&
                      (cnt_reg == dtr_pkg::FIFO_FULL_COUNT - 4'h1);
    wire trig_end   = running && !begin_trace && trig_now;
    wire auto_end   = fill_done || trig_end;

    // Sequencer
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            dtr_pkg::ST_IDLE:
                if (start_run)
                    state_next = begin_trace ? dtr_pkg::ST_WAIT_TRG
                                             : dtr_pkg::ST_STORE;
            dtr_pkg::ST_WAIT_TRG:
                if (manual_stop || !running)
                    state_next = dtr_pkg::ST_IDLE;
                else if (event_mode &&
                         (mode == dtr_pkg::MODE_EVENT_B || a_seen_reg))
                    state_next = dtr_pkg::ST_STORE;
                else if (!event_mode && trig_now)
                    state_next = dtr_pkg::ST_STORE;
            dtr_pkg::ST_STORE:
                if (manual_stop || auto_end || !running)
                    state_next = dtr_pkg::ST_IDLE;
            default:
                state_next = dtr_pkg::ST_IDLE;
        endcase
    end

    // Valid word count, saturating at eight, never lowered by reads
    always_comb
    begin
        cnt_next = cnt_reg;
        if (start_run)
            cnt_next = 4'h0;
        else if (store_word && !cnt_full)
            cnt_next = cnt_reg + 4'h1;
    end

    // Read data select
    wire [7:0] status_view = {af_reg, bf_reg,
                              enabled & armed, 1'b0, cnt_reg};
    wire [7:0] rd_sel =
        (reg_addr_i == dtr_pkg::ADDR_TRIG_CFG) ? cfg_reg :
        (reg_addr_i == dtr_pkg::ADDR_STATUS)   ? status_view :
        (reg_addr_i == dtr_pkg::ADDR_CONTROL)  ? ctl_reg : 8'h00;

    // Control with secure gating and automatic clear
    wire [7:0] ctl_wr = reg_wdata_i & dtr_pkg::CTL_WRITE_MASK;
    wire       en_wr  = ctl_wr[dtr_pkg::CTL_ENABLE_BIT] &&
                        (!sec_reg || enabled);
    wire [7:0] ctl_new = {en_wr, ctl_wr[6] && en_wr, ctl_wr[5:0]};

    // Security strap synchroniser
    always_ff @(posedge clk_i)
    begin
        sec_meta_reg <= secure_i;
        sec_reg      <= sec_meta_reg;
    end

    // Next value of the trigger configuration
    wire       cfg_wr_ok = wr_cfg && !armed;
    wire [7:0] cfg_next  = cfg_wr_ok ?
                           (reg_wdata_i & dtr_pkg::CFG_WRITE_MASK) :
                           cfg_reg;

    // Next value of the control copy
    logic [7:0] ctl_next;
    always_comb
    begin
        ctl_next = ctl_reg;
        if (wr_ctl)
            ctl_next = ctl_new;
        else if (auto_end)
            ctl_next[dtr_pkg::CTL_RUN_BIT] = 1'b0;
    end

    // Sequencer state
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            state_reg <= dtr_pkg::ST_IDLE;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Valid word count
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            cnt_reg <= 4'h0;
        end
        else
        begin
            cnt_reg <= cnt_next;
        end
    end

    // Trigger configuration
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            cfg_reg <= dtr_pkg::CFG_RESET;
        end
        else
        begin
            cfg_reg <= cfg_next;
        end
    end

    // Control copy
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            ctl_reg <= dtr_pkg::CTL_RESET;
        end
        else
        begin
            ctl_reg <= ctl_next;
        end
    end

    // Match flags for comparators A and B; writes reach them only through a run start, which clears both
    wire [1:0] hit_ab = {hit_a, hit_b};
    wire [1:0] flag_view;
    generate
        for (genvar g = 0; g < 2; g++)
        begin : g_flag
            logic flag_reg;
            wire  flag_next = start_run ? 1'b0 :
                              running   ? (flag_reg | hit_ab[g]) :
                              flag_reg;
            always_ff @(posedge clk_i)
            begin
                if (!reset_n_i)
                begin
                    flag_reg <= 1'b0;
                end
                else
                begin
                    flag_reg <= flag_next;
                end
            end
            assign flag_view[g] = flag_reg;
        end
    endgenerate
    assign af_reg = flag_view[1];
    assign bf_reg = flag_view[0];

    // A seen within this run, for the sequenced modes
    wire a_seen_next = start_run ? 1'b0 :
                       running   ? (a_seen_reg | hit_a) : a_seen_reg;
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            a_seen_reg <= 1'b0;
        end
        else
        begin
            a_seen_reg <= a_seen_next;
        end
    end

    // Read answer, zero outside its cycle
    wire [7:0] rdata_next = reg_read_i ? rd_sel : 8'h00;
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            rdata_reg <= dtr_pkg::STS_RESET;
        end
        else
        begin
            rdata_reg <= rdata_next;
        end
    end

    // Store pulse, one per valid word
    wire store_next = store_word && !cnt_full;
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            store_reg <= 1'b0;
        end
        else
        begin
            store_reg <= store_next;
        end
    end

    // Event-only byte marker
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            hbz_reg <= 1'b0;
        end
        else
        begin
            hbz_reg <= event_mode;
        end
    end

    // Trigger pulse while running
    wire trg_next = running && trig_now;
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            trg_reg <= 1'b0;
        end
        else
        begin
            trg_reg <= trg_next;
        end
    end

    // Break request at automatic run end
    wire brk_next = ctl_reg[dtr_pkg::CTL_BREAK_BIT] && auto_end;
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            brk_reg <= 1'b0;
        end
        else
        begin
            brk_reg <= brk_next;
        end
    end

    assign reg_rdata_o      = rdata_reg;
    assign fifo_store_o     = store_reg;
    assign high_byte_zero_o = hbz_reg;
    assign break_req_o      = brk_reg;
    assign trigger_o        = trg_reg;

endmodule

// *** pkg/dtr_pkg.sv ***
package dtr_pkg;

    // Register indices on the plain register port
    localparam logic [1:0] ADDR_TRIG_CFG = 2'h0;
    localparam logic [1:0] ADDR_STATUS   = 2'h1;
    localparam logic [1:0] ADDR_CONTROL  = 2'h2;

    // Trigger configuration fields
    localparam int CFG_QUALIFY_BIT = 7;
    localparam int CFG_BEGIN_BIT   = 6;
    localparam logic [7:0] CFG_WRITE_MASK = 8'hcf;
    localparam logic [7:0] CFG_RESET      = 8'h00;

    // Control register fields
    localparam int CTL_ENABLE_BIT = 7;
    localparam int CTL_RUN_BIT    = 6;
    localparam int CTL_BREAK_BIT  = 4;
    localparam logic [7:0] CTL_WRITE_MASK = 8'hd0;
    localparam logic [7:0] CTL_RESET      = 8'h00;

    // Status fields
    localparam int STS_AF_BIT  = 7;
    localparam int STS_BF_BIT  = 6;
    localparam int STS_RUN_BIT = 5;
    localparam logic [7:0] STS_RESET = 8'h00;

    // Trigger modes
    localparam logic [3:0] MODE_A_ONLY     = 4'h0;
    localparam logic [3:0] MODE_A_OR_B     = 4'h1;
    localparam logic [3:0] MODE_A_THEN_B   = 4'h2;
    localparam logic [3:0] MODE_EVENT_B    = 4'h3;
    localparam logic [3:0] MODE_A_EVENT_B  = 4'h4;
    localparam logic [3:0] MODE_A_AND_B    = 4'h5;
    localparam logic [3:0] MODE_A_AND_NB   = 4'h6;
    localparam logic [3:0] MODE_INSIDE     = 4'h7;
    localparam logic [3:0] MODE_OUTSIDE    = 4'h8;

    // FIFO depth
    localparam logic [3:0] FIFO_FULL_COUNT = 4'h8;

    typedef enum logic [2:0] {
        ST_IDLE     = 3'b001,
        ST_WAIT_TRG = 3'b010,
        ST_STORE    = 3'b100
    } dtr_state_t;

endpackage

// *** bench/dtr_trigger_status_monitor.sv ***
`timescale 1ns/1ps
module dtr_trigger_status_monitor (
    // Watched ports
    input wire logic       clk_i,
    input wire logic       reset_n_i,
    input wire logic [1:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       reg_write_i,
    input wire logic       reg_read_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       secure_i,
    input wire logic       break_req_o,
    input wire logic       trigger_o
);
    logic brk_reg;
    logic en_reg;
    wire  ctl_wr = reg_write_i && reg_addr_i == 2'h2;
    wire  st_rd  = reg_read_i && reg_addr_i == 2'h1;
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            brk_reg <= 1'b0;
            en_reg  <= 1'b0;
        end
        else if (ctl_wr)
        begin
            brk_reg <= reg_wdata_i[4];
            en_reg  <= reg_wdata_i[7];
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    chk_cfg_reserved: assert property (
        $past(reg_read_i && reg_addr_i == 2'h0) |-> reg_rdata_o[5:4] == 2'h0)
        else $error("config reserved bits not zero");
    chk_count_range: assert property (
        $past(st_rd) |-> reg_rdata_o[3:0] <= 4'h8)
        else $error("valid count above eight");
    chk_status_bit4: assert property (
        $past(st_rd) |-> !reg_rdata_o[4])
        else $error("status bit 4 set");
    chk_stop_clears: assert property (
        ctl_wr && !(reg_wdata_i[7] && reg_wdata_i[6]) ##1 !ctl_wr ##1 st_rd
        |=> !reg_rdata_o[5])
        else $error("run flag survived stop");
    chk_trig_stop: assert property (
        ctl_wr && !reg_wdata_i[6] ##1 !ctl_wr |=> !trigger_o)
        else $error("trigger after stop");
    chk_break_gate: assert property (
        break_req_o |-> brk_reg || $past(brk_reg))
        else $error("break without enable");
    chk_secure_block: assert property (
        secure_i [*3] ##0 (ctl_wr && !en_reg) ##1 !ctl_wr ##1 st_rd
        |=> !reg_rdata_o[5])
        else $error("enable taken while secured");
    chk_reset_quiet: assert property (disable iff (1'b0)
        !reset_n_i |=> reg_rdata_o == 8'h00 && !trigger_o && !break_req_o)
        else $error("outputs active after reset");
    cover property (trigger_o);
    cover property (break_req_o);
    cover property (st_rd ##1 reg_rdata_o[3:0] == 4'h8);
endmodule
bind dtr_trigger_status dtr_trigger_status_monitor u_mon (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i),
    .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o),
    .secure_i(secure_i), .break_req_o(break_req_o), .trigger_o(trigger_o));

// *** bench/dtr_bus_source.sv ***
`timescale 1ns/1ps
module dtr_bus_source (
    // Random CPU bus activity
    input  wire logic       clk_i,
    input  wire logic       run_i,
    output logic      [6:0] ev_o
);
    always_ff @(posedge clk_i)
        ev_o <= run_i ? 7'($urandom) : 7'h00;
endmodule

// *** bench/dtr_trigger_status_tb.sv ***
`timescale 1ns/1ps
module dtr_trigger_status_tb;
    logic       clk_i = 1'b0;
    logic       reset_n_i = 1'b0;
    logic [1:0] reg_addr_i = 2'h0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic       reg_write_i = 1'b0;
    logic       reg_read_i = 1'b0;
    logic       secure_i = 1'b0;
    logic       rnd_en = 1'b0;
    logic [6:0] drv = 7'h00;
    logic [6:0] rnd_ev;
    logic [6:0] ev;
    logic [7:0] reg_rdata_o;
    logic [7:0] d;
    logic       hbz;
    logic       brk;
    logic       trigger_mode_field;
    logic       sto;
    logic       clr_store = 1'b0;
    int         n_store = 0;
    int         n_mismatch = 0;
    int         samples_checked = 0;
    int         i;
    assign ev = rnd_en ? rnd_ev : drv;
    always #12.5 clk_i = ~clk_i;
    dtr_trigger_status dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
        .reg_rdata_o(reg_rdata_o), .secure_i(secure_i),
        .bus_access_i(ev[5]), .opcode_exec_i(ev[6]),
        .match_a_addr_i(ev[4]), .match_b_addr_i(ev[3]),
        .match_b_data_i(ev[2]), .addr_ge_a_i(ev[1]), .addr_le_b_i(ev[0]),
        .fifo_store_o(sto), .high_byte_zero_o(hbz), .break_req_o(brk),
        .trigger_o(trigger_mode_field));
    dtr_bus_source u_src (.clk_i(clk_i), .run_i(rnd_en), .ev_o(rnd_ev));
    always @(posedge clk_i)
        n_store <= clr_store ? 0 : n_store + ((sto === 1'b1) ? 1 : 0);
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic check(string what, logic [7:0] exp, logic [7:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(logic [1:0] a, logic [7:0] v);
        reg_addr_i <= a;
        reg_wdata_i <= v;
        reg_write_i <= 1'b1;
        @(posedge clk_i);
        reg_write_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(logic [1:0] a);
        reg_addr_i <= a;
        reg_read_i <= 1'b1;
        @(posedge clk_i);
        reg_read_i <= 1'b0;
        #1 d = reg_rdata_o;
        @(posedge clk_i);
    endtask
    task automatic trig_case(logic [7:0] cfg, logic [6:0] vec, logic e);
        logic t;
        logic b;
        t = 1'b0;
        b = 1'b0;
        wr(2'h0, cfg);
        wr(2'h2, 8'hd0);
        drv <= vec;
        @(posedge clk_i);
        drv <= 7'h00;
        repeat (4)
        begin
            @(negedge clk_i);
            t = t | (trigger_mode_field === 1'b1);
            b = b | (brk === 1'b1);
        end
        @(posedge clk_i);
        rd(2'h1);
        check("trigger", {7'h0, e}, {7'h0, t});
        check("break", {7'h0, e}, {7'h0, b});
        check("auto end", {2'h0, ~e, 5'h0}, d & 8'h20);
        wr(2'h2, 8'h00);
    endtask
    initial
    begin
        void'($urandom(32'h871f));
        repeat (20) @(posedge clk_i);
        reset_n_i <= 1'b1;
        rd(2'h0);
        check("cfg reset", 8'h00, d);
        rd(2'h1);
        check("status reset", 8'h00, d);
        rd(2'h3);
        check("unmapped", 8'h00, d);
        wr(2'h0, 8'hff);
        rd(2'h0);
        check("cfg", 8'hcf, d);
        wr(2'h2, 8'hc0);
        wr(2'h0, 8'h00);
        wr(2'h1, 8'hff);
        rd(2'h0);
        check("cfg armed", 8'hcf, d);
        rd(2'h1);
        check("status armed", 8'h20, d);
        wr(2'h2, 8'h40);
        rd(2'h1);
        check("status off", 8'h00, d);
        secure_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        wr(2'h2, 8'hc0);
        rd(2'h1);
        check("secured", 8'h00, d & 8'h20);
        secure_i <= 1'b0;
        wr(2'h2, 8'h00);
        trig_case(8'h00, 7'h30, 1'b1);
        check("a flag", 8'h80, d & 8'hc0);
        rd(2'h1);
        check("a flag held", 8'h80, d & 8'hc0);
        trig_case(8'h80, 7'h30, 1'b0);
        trig_case(8'h80, 7'h70, 1'b1);
        trig_case(8'h01, 7'h28, 1'b1);
        trig_case(8'h07, 7'h23, 1'b1);
        trig_case(8'h07, 7'h22, 1'b0);
        trig_case(8'h08, 7'h21, 1'b1);
        trig_case(8'h08, 7'h23, 1'b0);
        trig_case(8'h05, 7'h34, 1'b1);
        trig_case(8'h05, 7'h30, 1'b0);
        trig_case(8'h06, 7'h30, 1'b1);
        trig_case(8'h06, 7'h34, 1'b0);
        for (i = 9; i < 16; i++)
            trig_case(8'(i), 7'($urandom), 1'b0);
        clr_store <= 1'b1;
        wr(2'h0, 8'h03);
        wr(2'h2, 8'hc0);
        clr_store <= 1'b0;
        rnd_en <= 1'b1;
        @(negedge clk_i);
        check("high byte", 8'h01, {7'h0, hbz});
        @(posedge clk_i);
        i = 0;
        do
        begin
            rd(2'h1);
            i++;
        end
        while (d[5] && i < 300);
        if (i >= 300)
        begin
            n_mismatch++;
            finish_test();
        end
        check("event end", 8'h48, d & 8'h7f);
        check("stores", 8'h08, 8'(n_store));
        repeat (10) @(posedge clk_i);
        rd(2'h1);
        check("held", 8'h48, d & 8'h7f);
        rnd_en <= 1'b0;
        wr(2'h0, 8'h04);
        wr(2'h2, 8'hc0);
        drv <= 7'h28;
        repeat (3) @(posedge clk_i);
        drv <= 7'h00;
        rd(2'h1);
        check("b before a", 8'h00, d & 8'h0f);
        finish_test();
    end
endmodule
